// ### src/qdw_buf_calc.sv
// buffer address and page advance for the current descriptor position
`timescale 1ns/1ns
module qdw_buf_calc
	import qdw_pkg::*;
(
	// position in and out
	qdw_buf_if.calc bi
);
	logic [15:0] sum;

	// offset carries into the page index; pages need not be adjacent
	always_comb begin
		sum           = {4'h0, bi.offset} + {1'b0, bi.moved};
		bi.buf_addr   = {bi.page_base, bi.offset}; // RL6
		bi.new_offset = sum[11:0];
		bi.new_cpage  = bi.cpage + sum[14:12]; // RL5
		bi.page_bad   = bi.cpage > QDW_MAX_CPAGE; // RL18
	end
endmodule

// ### src/qdw_buf_if.sv
// buffer position signals between the walker and its address calculator
`timescale 1ns/1ns
interface qdw_buf_if;
	logic [19:0] page_base;
	logic [11:0] offset;
	logic [2:0]  cpage;
	logic [14:0] moved;
	logic [31:0] buf_addr;
	logic [11:0] new_offset;
	logic [2:0]  new_cpage;
	logic        page_bad;
	modport calc (input page_base, offset, cpage, moved, output buf_addr, new_offset, new_cpage, page_bad);
	modport user (output page_base, offset, cpage, moved, input buf_addr, new_offset, new_cpage, page_bad);
endinterface

// ### src/qdw_irq.sv
// sticky interrupt status with enable and write-one-to-clear
`timescale 1ns/1ns
module qdw_irq
	import qdw_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	// events and software access
	input  wire logic [QDW_IRQ_W-1:0] ev_set,
	input  wire logic                 clr_we,
	input  wire logic                 en_we,
	input  wire logic [QDW_IRQ_W-1:0] wdata,
	// state out
	output logic      [QDW_IRQ_W-1:0] status,
	output logic      [QDW_IRQ_W-1:0] enable,
	output logic                      irq
);
	typedef struct packed {
		logic [QDW_IRQ_W-1:0] status;
		logic [QDW_IRQ_W-1:0] enable;
		logic                 irq;
	} qdw_irq_t;

	qdw_irq_t s;
	qdw_irq_t next_s;

	// a set in the clearing cycle wins, so no event is lost
	always_comb begin
		next_s        = s;
		next_s.status = (s.status & ~(clr_we ? wdata : '0)) | ev_set;
		if (en_we) begin
			next_s.enable = wdata;
		end
		next_s.irq = |(next_s.status & next_s.enable);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s <= '{status: '0, enable: QDW_RST_IRQ_EN, irq: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign status = s.status;
	assign enable = s.enable;
	assign irq    = s.irq;
endmodule

// ### src/qdw_pkg.sv
// constants, layouts and state codes of the queue element descriptor walker
//------------------------------------------------------------------------------
// Behaviour
// RL1 - one descriptor moves at most 20480 bytes over five 4096-byte pages
// RL2 - descriptor is 32 bytes: two links, one token word, five page words
// RL3 - descriptors sit on 32-byte boundaries; low five address bits ignored
// RL4 - each descriptor is one contiguous block, read with linear addresses
// RL5 - software gives one page pointer per physical page touched
// RL6 - buffer may start on any byte; offset is low bits of page 0 word
// RL7 - descriptor written back only at retirement, never mid transfer
// RL8 - write back touches only toggle, count, page, error count, status, offset
// RL9 - next descriptor address is link word 0 bits 31..5, low bits zero
// RL10 - link bits 4..1 are ignored
// RL11 - link bit 0 clear means valid, set means no further entries
// RL12 - retirement on short packet follows the alternate link
// RL13 - alternate address is word 1 bits 31..5, used for short IN packets
// RL14 - alternate link at 0x04, token at 0x08, last page pointer at 0x1C
// RL15 - the first descriptor is reached through the queue head pointer
// RL16 - count bits 30..16 drop by bytes moved on success; zero count sends once
// RL17 - token bit 15 raises completion interrupt when descriptor completes
// RL18 - token bits 14..12 select a page pointer; only 0 to 4 valid
// RL19 - all eight words fetched as one burst before any transaction
//------------------------------------------------------------------------------
package qdw_pkg;
	// descriptor geometry
	localparam int QDW_MAX_BYTES  = 20480;
	localparam int QDW_PAGE_BYTES = 4096;
	localparam int QDW_DESC_WORDS = 8;
	localparam logic [3:0] QDW_FETCH_BEATS = 4'h8;
	localparam logic [3:0] QDW_WB_BEATS    = 4'h2;
	// byte offsets inside a descriptor and their word indices
	localparam logic [4:0] QDW_OFF_NEXT  = 5'h00;
	localparam logic [4:0] QDW_OFF_ALT   = 5'h04;
	localparam logic [4:0] QDW_OFF_TOKEN = 5'h08;
	localparam logic [4:0] QDW_OFF_PAGE0 = 5'h0C;
	localparam logic [4:0] QDW_OFF_PAGE4 = 5'h1C;
	localparam logic [2:0] QDW_W_NEXT  = QDW_OFF_NEXT[4:2];
	localparam logic [2:0] QDW_W_ALT   = QDW_OFF_ALT[4:2];
	localparam logic [2:0] QDW_W_TOKEN = QDW_OFF_TOKEN[4:2];
	localparam logic [2:0] QDW_W_PAGE0 = QDW_OFF_PAGE0[4:2];
	localparam logic [2:0] QDW_W_PAGE4 = QDW_OFF_PAGE4[4:2];
	// link and token fields
	localparam int QDW_LINK_TERM = 0;
	localparam int QDW_TOK_TOGGLE = 31;
	localparam int QDW_TOK_IOC    = 15;
	localparam int QDW_STS_ACTIVE = 7;
	localparam int QDW_STS_HALTED = 6;
	localparam logic [1:0]  QDW_PID_IN     = 2'h1;
	localparam logic [2:0]  QDW_MAX_CPAGE  = 3'h4;
	localparam logic [14:0] QDW_MAX_COUNT  = 15'h5000;
	// register byte offsets
	localparam logic [7:0] QDW_REG_CTRL       = 8'h00;
	localparam logic [7:0] QDW_REG_HEAD       = 8'h04;
	localparam logic [7:0] QDW_REG_IRQ_STATUS = 8'h08;
	localparam logic [7:0] QDW_REG_IRQ_CLEAR  = 8'h0C;
	localparam logic [7:0] QDW_REG_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] QDW_REG_CURRENT    = 8'h14;
	localparam logic [7:0] QDW_REG_TOKEN      = 8'h18;
	localparam int QDW_CTRL_RUN  = 0;
	localparam int QDW_CTRL_GO   = 1;
	localparam int QDW_CTRL_BUSY = 2;
	// interrupt bits
	localparam int QDW_IRQ_W     = 4;
	localparam int QDW_IRQ_DONE  = 0;
	localparam int QDW_IRQ_END   = 1;
	localparam int QDW_IRQ_HALT  = 2;
	localparam int QDW_IRQ_SHORT = 3;
	localparam logic [QDW_IRQ_W-1:0] QDW_RST_IRQ_EN = 4'h0;
	// walker states
	typedef enum logic [5:0] {
		QDW_IDLE  = 6'h01,
		QDW_FETCH = 6'h02,
		QDW_EXEC  = 6'h04,
		QDW_WAIT  = 6'h08,
		QDW_WBACK = 6'h10,
		QDW_LINK  = 6'h20
	} qdw_state_t;
endpackage

// ### src/qdw_walker.sv
// queue element descriptor walker with AHB-Lite registers
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
module qdw_walker
	import qdw_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// descriptor memory master
	output logic             mem_cmd_valid,
	output logic             mem_cmd_write,
	output logic      [31:0] mem_cmd_addr,
	output logic      [3:0]  mem_cmd_beats,
	input  wire logic        mem_cmd_ready,
	input  wire logic        mem_rvalid,
	input  wire logic [31:0] mem_rdata,
	output logic             mem_wvalid,
	output logic      [31:0] mem_wdata,
	input  wire logic        mem_wready,
	// transaction engine
	output logic             txn_start,
	output logic      [31:0] txn_addr,
	output logic      [14:0] txn_bytes,
	output logic             toggle_bit,
	output logic      [1:0]  txn_pid,
	input  wire logic        txn_done,
	input  wire logic        txn_ok,
	input  wire logic        txn_short,
	input  wire logic        txn_err,
	input  wire logic [14:0] txn_moved,
	input  wire logic        txn_toggle_next,
	// interrupt
	output logic             irq
);
	//--------------------------------------------------------------------------
	// state
	//--------------------------------------------------------------------------
	typedef struct packed {
		qdw_state_t           fsm;
		logic [7:0][31:0]     w;
		logic [31:0]          ptr;
		logic [31:0]          head;
		logic                 run;
		logic [2:0]           beat;
		logic                 alt_sel;
		logic                 halted;
		logic [7:0]           a_addr;
		logic                 a_wr;
		logic                 a_rd;
		logic [31:0]          hrdata;
		logic                 hreadyout;
		logic                 cmd_valid;
		logic                 cmd_write;
		logic [31:0]          cmd_addr;
		logic [3:0]           cmd_beats;
		logic                 wvalid;
		logic [31:0]          wdata;
		logic                 t_start;
		logic [31:0]          t_addr;
		logic [14:0]          t_bytes;
		logic                 t_toggle;
		logic [1:0]           t_pid;
		logic [QDW_IRQ_W-1:0] ev;
	} qdw_walk_t;

	qdw_walk_t            s;
	qdw_walk_t            n;
	logic [QDW_IRQ_W-1:0] irq_status;
	logic [QDW_IRQ_W-1:0] irq_enable;
	logic [31:0]          tok;
	logic [14:0]          tok_bytes;
	logic [2:0]           tok_cpage;
	logic [1:0]           tok_cerr;
	logic [1:0]           tok_pid;
	logic [3:0]           pg_idx;
	logic [31:0]          pg_word;
	logic [31:0]          cur_link;
	logic [31:0]          link_addr;
	logic                 sel;

	qdw_buf_if bi ();

	qdw_buf_calc u_calc (
		.bi (bi.calc)
	);

	qdw_irq u_irq (
		.clk_sys (clk_sys),
		.reset   (reset),
		.ev_set  (s.ev),
		.clr_we  (s.a_wr && s.a_addr == QDW_REG_IRQ_CLEAR),
		.en_we   (s.a_wr && s.a_addr == QDW_REG_IRQ_ENABLE),
		.wdata   (hwdata[QDW_IRQ_W-1:0]),
		.status  (irq_status),
		.enable  (irq_enable),
		.irq     (irq)
	);

	//--------------------------------------------------------------------------
	// descriptor field views
	//--------------------------------------------------------------------------
	// token fields and the page word picked by the current page index
	always_comb begin
		tok       = s.w[QDW_W_TOKEN]; // RL14
		tok_bytes = tok[30:16];
		tok_cpage = tok[14:12];
		tok_cerr  = tok[11:10];
		tok_pid   = tok[9:8];
		pg_idx    = {1'b0, QDW_W_PAGE0} + {1'b0, tok_cpage}; // RL18
		pg_word   = (pg_idx <= {1'b0, QDW_W_PAGE4}) ? s.w[pg_idx[2:0]] : '0;
		cur_link  = s.alt_sel ? s.w[QDW_W_ALT] : s.w[QDW_W_NEXT]; // RL12 RL13
		link_addr = {cur_link[31:5], 5'h00}; // RL9 RL10
	end

	assign bi.page_base = pg_word[31:12];
	assign bi.offset    = s.w[QDW_W_PAGE0][11:0];
	assign bi.cpage     = tok_cpage;
	assign bi.moved     = txn_moved;
	assign sel          = hsel && htrans[1] && hready;

	//--------------------------------------------------------------------------
	// next state
	//--------------------------------------------------------------------------
	// bus slave, walker sequence and write back kick-off in one pass
	always_comb begin
		logic        go;
		logic        retire;
		logic        fetch;
		logic [31:0] fetch_addr;
		go         = 1'b0;
		retire     = 1'b0;
		fetch      = 1'b0;
		fetch_addr = s.head;
		n           = s;
		n.ev        = '0;
		n.t_start   = 1'b0;
		n.a_wr      = 1'b0;
		n.hreadyout = 1'b1;
		// write data phase, no wait state
		if (s.a_wr && s.a_addr == QDW_REG_CTRL) begin
			n.run = hwdata[QDW_CTRL_RUN];
			go    = hwdata[QDW_CTRL_GO];
		end
		if (s.a_wr && s.a_addr == QDW_REG_HEAD) begin
			n.head = {hwdata[31:5], 5'h00}; // RL3
		end
		// reads take one wait state so a preceding write is already visible
		if (s.a_rd) begin
			n.a_rd      = 1'b0;
			unique case (s.a_addr)
				QDW_REG_CTRL:       n.hrdata = {29'h0, s.fsm != QDW_IDLE, 1'b0, s.run};
				QDW_REG_HEAD:       n.hrdata = s.head;
				QDW_REG_IRQ_STATUS: n.hrdata = {28'h0, irq_status};
				QDW_REG_IRQ_ENABLE: n.hrdata = {28'h0, irq_enable};
				QDW_REG_CURRENT:    n.hrdata = s.ptr;
				QDW_REG_TOKEN:      n.hrdata = tok;
				default:            n.hrdata = 32'h0;
			endcase
		end
		if (sel) begin
			n.a_addr = haddr[7:0];
			n.a_wr   = hwrite;
			n.a_rd   = !hwrite;
			if (!hwrite) begin
				n.hreadyout = 1'b0;
			end
		end
		unique case (s.fsm)
			QDW_IDLE: begin
				// the walk only starts from the queue head pointer
				if (go && n.run) begin
					fetch = 1'b1; // RL15
				end
			end
			QDW_FETCH: begin
				if (s.cmd_valid && mem_cmd_ready) begin
					n.cmd_valid = 1'b0;
				end
				if (mem_rvalid) begin
					n.w[s.beat] = mem_rdata; // RL2 RL4
					n.beat      = s.beat + 3'h1;
					if (s.beat == 3'h7) begin
						n.fsm = QDW_EXEC; // RL19
					end
				end
			end
			QDW_EXEC: begin
				if (!tok[QDW_STS_ACTIVE]) begin
					n.fsm = QDW_LINK;
				end else if (tok_bytes > QDW_MAX_COUNT || bi.page_bad) begin
					// oversize count or bad page index halts the queue
					n.w[QDW_W_TOKEN][QDW_STS_HALTED] = 1'b1; // RL1 RL18
					n.halted = 1'b1;
					retire   = 1'b1;
				end else begin
					n.t_start  = 1'b1;
					n.t_addr   = bi.buf_addr; // RL6
					n.t_bytes  = tok_bytes; // RL16
					n.t_toggle = tok[QDW_TOK_TOGGLE];
					n.t_pid    = tok_pid;
					n.fsm      = QDW_WAIT;
				end
			end
			QDW_WAIT: begin
				if (txn_done && txn_err) begin
					// a count of zero retries without limit
					if (tok_cerr == 2'h1) begin
						n.w[QDW_W_TOKEN][11:10]          = 2'h0;
						n.w[QDW_W_TOKEN][QDW_STS_HALTED] = 1'b1;
						n.halted = 1'b1;
						retire   = 1'b1;
					end else begin
						if (tok_cerr != 2'h0) begin
							n.w[QDW_W_TOKEN][11:10] = tok_cerr - 2'h1; // RL8
						end
						n.fsm = QDW_EXEC;
					end
				end else if (txn_done && txn_ok) begin
					n.w[QDW_W_TOKEN][30:16]          = tok_bytes - txn_moved; // RL16
					n.w[QDW_W_TOKEN][14:12]          = bi.new_cpage;
					n.w[QDW_W_TOKEN][QDW_TOK_TOGGLE] = txn_toggle_next;
					n.w[QDW_W_PAGE0][11:0]           = bi.new_offset; // RL8
					n.alt_sel = txn_short && tok_pid == QDW_PID_IN; // RL13
					if (tok_bytes == txn_moved || n.alt_sel) begin
						retire = 1'b1; // RL12
					end else begin
						n.fsm = QDW_EXEC;
					end
				end else if (txn_done) begin
					n.fsm = QDW_EXEC;
				end
			end
			QDW_WBACK: begin
				// token first, then page 0; data follows the accepted command
				if (s.cmd_valid && mem_cmd_ready) begin
					n.cmd_valid = 1'b0;
					n.wvalid    = 1'b1;
					n.wdata     = s.w[QDW_W_TOKEN];
				end
				if (s.wvalid && mem_wready) begin
					if (s.beat == 3'h0) begin
						n.beat  = 3'h1;
						n.wdata = s.w[QDW_W_PAGE0]; // RL8
					end else begin
						n.wvalid                = 1'b0;
						n.ev[QDW_IRQ_DONE]  = tok[QDW_TOK_IOC]; // RL17
						n.ev[QDW_IRQ_HALT]  = s.halted;
						n.ev[QDW_IRQ_SHORT] = s.alt_sel;
						n.fsm = s.halted ? QDW_IDLE : QDW_LINK;
					end
				end
			end
			QDW_LINK: begin
				if (cur_link[QDW_LINK_TERM]) begin
					n.ev[QDW_IRQ_END] = 1'b1; // RL11
					n.fsm = QDW_IDLE;
				end else if (!s.run) begin
					n.fsm = QDW_IDLE;
				end else begin
					fetch      = 1'b1;
					fetch_addr = link_addr; // RL9
				end
			end
		endcase
		// retirement is the only place that writes memory
		if (retire) begin
			n.w[QDW_W_TOKEN][QDW_STS_ACTIVE] = 1'b0; // RL7
			n.fsm       = QDW_WBACK;
			n.beat      = 3'h0;
			n.cmd_valid = 1'b1;
			n.cmd_write = 1'b1;
			n.cmd_addr  = {s.ptr[31:5], QDW_OFF_TOKEN};
			n.cmd_beats = QDW_WB_BEATS;
			n.wvalid    = 1'b0;
		end
		if (fetch) begin
			n.fsm       = QDW_FETCH;
			n.ptr       = fetch_addr;
			n.beat      = 3'h0;
			n.alt_sel   = 1'b0;
			n.halted    = 1'b0;
			n.cmd_valid = 1'b1;
			n.cmd_write = 1'b0;
			n.cmd_addr  = fetch_addr; // RL3
			n.cmd_beats = QDW_FETCH_BEATS; // RL19
		end
	end

	//--------------------------------------------------------------------------
	// registers and outputs
	//--------------------------------------------------------------------------
	// whole state resets to idle with the bus ready
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s           <= '0;
			s.fsm       <= QDW_IDLE;
			s.hreadyout <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign hreadyout     = s.hreadyout;
	assign hresp         = 1'b0;
	assign hrdata        = s.hrdata;
	assign mem_cmd_valid = s.cmd_valid;
	assign mem_cmd_write = s.cmd_write;
	assign mem_cmd_addr  = s.cmd_addr;
	assign mem_cmd_beats = s.cmd_beats;
	assign mem_wvalid    = s.wvalid;
	assign mem_wdata     = s.wdata;
	assign txn_start     = s.t_start;
	assign txn_addr      = s.t_addr;
	assign txn_bytes     = s.t_bytes;
	assign toggle_bit    = s.t_toggle;
	assign txn_pid       = s.t_pid;

	//--------------------------------------------------------------------------
	// assertions
	//--------------------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence s_last_beat;
		s.fsm == QDW_FETCH && mem_rvalid && s.beat == 3'h7;
	endsequence

	sequence s_zero_count;
		s.fsm == QDW_EXEC && tok[QDW_STS_ACTIVE] && tok_bytes == 15'h0 && !bi.page_bad;
	endsequence

	a_fetch_aligned: assert property (mem_cmd_valid && !mem_cmd_write |-> // RL3
		mem_cmd_addr[4:0] == 5'h00 && mem_cmd_beats == QDW_FETCH_BEATS)
		else $error("fetch not aligned eight word burst");
	a_burst_first: assert property (s_last_beat |=> s.fsm == QDW_EXEC) // RL19
		else $error("walker did not execute after full fetch");
	a_retire_only: assert property (mem_cmd_valid && mem_cmd_write |-> s.fsm == QDW_WBACK) // RL7
		else $error("descriptor write outside retirement");
	a_keep_fields: assert property (mem_wvalid |-> // RL8
		mem_wdata[QDW_TOK_IOC] == tok[QDW_TOK_IOC] || mem_wdata[31:12] == s.w[QDW_W_PAGE0][31:12])
		else $error("write back altered a fixed field");
	a_link_follow: assert property (s.fsm == QDW_LINK && !cur_link[0] && s.run |=> // RL9
		s.fsm == QDW_FETCH && s.ptr == $past(link_addr))
		else $error("next descriptor address wrong");
	a_term_stop: assert property (s.fsm == QDW_LINK && cur_link[0] |=> // RL11
		s.fsm == QDW_IDLE && !mem_cmd_valid)
		else $error("terminated link was followed");
	a_short_alt: assert property (s.fsm == QDW_LINK && s.alt_sel && !cur_link[0] && s.run |=> // RL12
		s.ptr == {s.w[QDW_W_ALT][31:5], 5'h00})
		else $error("short packet did not take alternate link");
	a_zero_once: assert property (s_zero_count |=> txn_start && txn_bytes == 15'h0) // RL16
		else $error("zero length transaction not issued");
	a_count_down: assert property (s.fsm == QDW_WAIT && txn_done && txn_ok && !txn_err |=> // RL16
		tok_bytes == $past(tok_bytes) - $past(txn_moved))
		else $error("byte count not reduced by bytes moved");
	a_page_valid: assert property (txn_start |-> tok_cpage <= QDW_MAX_CPAGE && // RL18
		txn_addr[11:0] == s.w[QDW_W_PAGE0][11:0])
		else $error("transaction with bad page or offset");
endmodule

// ### test/qdw_mem_model.sv
// behavioural descriptor memory behind the walker's burst port
`timescale 1ns/1ns
module qdw_mem_model (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// command
	input  wire logic        mem_cmd_valid,
	input  wire logic        mem_cmd_write,
	input  wire logic [31:0] mem_cmd_addr,
	input  wire logic [3:0]  mem_cmd_beats,
	output logic             mem_cmd_ready,
	// data
	output logic             mem_rvalid,
	output logic      [31:0] mem_rdata,
	input  wire logic        mem_wvalid,
	input  wire logic [31:0] mem_wdata,
	output logic             mem_wready
);
	logic [31:0] mem [0:2047];
	logic [31:0] addr;
	logic [3:0]  left;
	logic [2:0]  cnt = 3'h0;
	logic        busy;
	logic        wr;

	// one burst at a time; cnt mixes prompt and stalled beats
	always @(posedge clk_sys) begin
		cnt <= cnt + 3'h1;
		mem_rvalid <= 1'b0;
		mem_rdata <= ~mem_rdata; // stale data alternates between the last valid word and its inverse
		if (reset) begin
			{busy, mem_cmd_ready, mem_wready} <= 3'h0;
			mem_rdata <= 32'h0;
		end else if (!busy) begin
			mem_cmd_ready <= cnt[0];
			if (mem_cmd_valid && mem_cmd_ready) begin
				{busy, wr, addr, left, mem_cmd_ready} <= {1'b1, mem_cmd_write, mem_cmd_addr, mem_cmd_beats, 1'b0};
			end
		end else if (!wr) begin
			// linear word addressing inside one contiguous record
			if (cnt[1]) begin
				mem_rvalid <= 1'b1;
				mem_rdata <= mem[addr[12:2]];
				addr <= addr + 32'h4;
				left <= left - 4'h1;
				busy <= (left != 4'h1);
			end
		end else begin
			mem_wready <= cnt[0];
			if (mem_wvalid && mem_wready) begin
				mem[addr[12:2]] <= mem_wdata;
				addr <= addr + 32'h4;
				left <= left - 4'h1;
				if (left == 4'h1) begin
					{busy, mem_wready} <= 2'h0;
				end
			end
		end
	end
endmodule

// ### test/tb_top.sv
// self-checking bench for the queue element descriptor walker
`timescale 1ns/1ns
module tb_top;
	import qdw_pkg::*;
	// bus and control
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, cmd_addr, rdata, wdata, txn_addr;
	logic        hreadyout, hresp, irq, cmd_valid, cmd_write, cmd_ready, rvalid, wvalid, wready;
	logic [3:0]  cmd_beats;
	// transaction engine
	logic        txn_start, toggle_bit, txn_ok = 1'b0, txn_short = 1'b0, txn_done = 1'b0, txn_tog = 1'b0;
	logic        txn_err = 1'b0;
	logic [1:0]  txn_pid;
	logic [14:0] txn_bytes, txn_moved = 15'h0;
	// scoreboard
	int          err_count = 0;
	int          checks = 0;
	logic [31:0] seed = 32'he38348e3;
	logic [31:0] r, lnk;
	logic [18:0] rsp;
	logic [50:0] exp_q [$];
	logic [18:0] rsp_q [$];

	always #20 clk_sys = ~clk_sys;

	qdw_walker dut_u (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .mem_cmd_valid(cmd_valid), .mem_cmd_write(cmd_write),
		.mem_cmd_addr(cmd_addr), .mem_cmd_beats(cmd_beats), .mem_cmd_ready(cmd_ready), .mem_rvalid(rvalid),
		.mem_rdata(rdata), .mem_wvalid(wvalid), .mem_wdata(wdata), .mem_wready(wready), .txn_start(txn_start),
		.txn_addr(txn_addr), .txn_bytes(txn_bytes), .toggle_bit(toggle_bit), .txn_pid(txn_pid),
		.txn_done(txn_done), .txn_ok(txn_ok), .txn_short(txn_short), .txn_err(txn_err), .txn_moved(txn_moved),
		.txn_toggle_next(txn_tog), .irq(irq));
	qdw_mem_model mem_u (.clk_sys(clk_sys), .reset(reset), .mem_cmd_valid(cmd_valid), .mem_cmd_write(cmd_write),
		.mem_cmd_addr(cmd_addr), .mem_cmd_beats(cmd_beats), .mem_cmd_ready(cmd_ready), .mem_rvalid(rvalid),
		.mem_rdata(rdata), .mem_wvalid(wvalid), .mem_wdata(wdata), .mem_wready(wready));

	//----------------------------------------
	// checking and bus tasks
	//----------------------------------------
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
		end
	endtask

	// an event with nothing noted against it is a mismatch too
	task automatic chk_event(input logic [50:0] got);
		logic [50:0] exp;
		exp = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t event got %h exp %h", $time, got, exp);
		end
	endtask

	// single word transfer; hold each phase until hready is seen high
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		for (int ph = 0; ph < 2; ph++) begin
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (hreadyout !== 1'b1 && n < 50);
			if (n >= 50) begin
				err_count++;
				end_of_test;
			end
			if (ph == 0) begin
				{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
			end
		end
		r = hrdata;
		chk_word({31'h0, hresp}, 32'h0);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk_word(r, e);
	endtask

	function automatic logic [31:0] mw(input logic [31:0] a);
		return mem_u.mem[a[12:2]];
	endfunction

	// one page pointer per page, pages 1..4 follow page 0
	task automatic put_desc(input logic [31:0] a, nxt, alt, tok, pg0);
		mem_u.mem[a[12:2]] = nxt;
		mem_u.mem[a[12:2] + 1] = alt;
		mem_u.mem[a[12:2] + 2] = tok;
		for (int k = 0; k < 5; k++) begin
			mem_u.mem[a[12:2] + 3 + k] = (k == 0) ? pg0 : {pg0[31:12] + 20'(k), 12'h0};
		end
	endtask

	// wait for all noted events, then for busy to drop
	task automatic wait_done;
		int n;
		n = 0;
		while (exp_q.size() > 0 && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		do begin
			ahb(1'b0, QDW_REG_CTRL, 32'h0);
			n++;
		end while (r[QDW_CTRL_BUSY] !== 1'b0 && n < 3100);
		if (r[QDW_CTRL_BUSY] !== 1'b0 || exp_q.size() > 0) begin
			err_count++;
			end_of_test;
		end
	endtask

	//----------------------------------------
	// transaction engine and output monitor
	//----------------------------------------
	always @(posedge clk_sys) begin
		txn_done <= 1'b0;
		if (txn_start === 1'b1) begin
			rsp = rsp_q.pop_front();
			repeat (3) @(posedge clk_sys);
			{txn_err, txn_ok, txn_short, txn_moved, txn_tog} <= rsp;
			txn_done <= 1'b1;
		end
	end

	always @(posedge clk_sys) begin
		if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
			chk_event({19'h0, cmd_addr});
		end
		if (txn_start === 1'b1) begin
			chk_event({1'b1, toggle_bit, txn_pid, txn_bytes, txn_addr});
		end
	end

	//----------------------------------------
	// main sequence
	//----------------------------------------
	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd(QDW_REG_CTRL, 32'h0);
		rd(QDW_REG_IRQ_ENABLE, 32'h0);
		rd(QDW_REG_IRQ_STATUS, 32'h0);
		ahb(1'b1, 32'h40, 32'hFFFF_FFFF);
		rd(32'h40, 32'h0);
		ahb(1'b1, QDW_REG_HEAD, 32'h0000_101F);
		rd(QDW_REG_HEAD, 32'h0000_1000);
		$display("test registers done");

		// chain: error retry then full retire, short IN to alternate, zero-length, terminate
		lnk = $random(seed);
		put_desc(32'h1000, 32'h1040 | (lnk & 32'h1E), 32'h1, 32'h0100_8C80, 32'h0000_2123);
		put_desc(32'h1040, 32'h10C0, 32'h1080 | (lnk & 32'h1E), 32'h8200_0D80, 32'h0000_3FF8);
		put_desc(32'h1080, 32'h1, 32'h10C1, 32'h0000_0C80, 32'h0000_4000);
		exp_q = '{{19'h0, 32'h1000}, {1'b1, 1'b0, 2'h0, 15'h100, 32'h2123},
			{1'b1, 1'b0, 2'h0, 15'h100, 32'h2123}, {19'h0, 32'h1008}, {19'h0, 32'h1040},
			{1'b1, 1'b1, 2'h1, 15'h200, 32'h3FF8}, {19'h0, 32'h1048}, {19'h0, 32'h1080},
			{1'b1, 1'b0, 2'h0, 15'h0, 32'h4000}, {19'h0, 32'h1088}};
		// error first, so the retry and the error count decrement are both exercised
		rsp_q = '{{3'b100, 15'h0, 1'b0}, {3'b010, 15'h100, 1'b1},
			{3'b011, 15'h10, 1'b0}, {3'b010, 15'h0, 1'b1}};
		ahb(1'b1, QDW_REG_HEAD, 32'h1000 | (lnk & 32'h1F));
		ahb(1'b1, QDW_REG_CTRL, 32'h3);
		wait_done;
		chk_word(mw(32'h1000), 32'h1040 | (lnk & 32'h1E));
		chk_word(mw(32'h1008), 32'h8000_8800);
		chk_word(mw(32'h100C), 32'h0000_2223);
		chk_word(mw(32'h1048), 32'h01F0_1D00);
		chk_word(mw(32'h104C), 32'h0000_3008);
		chk_word(mw(32'h1050), 32'h0000_4000);
		chk_word(mw(32'h1088), 32'h8000_0C00);
		rd(QDW_REG_IRQ_STATUS, 32'hB);
		chk_word({31'h0, irq}, 32'h0);
		ahb(1'b1, QDW_REG_IRQ_ENABLE, 32'hF);
		rd(QDW_REG_IRQ_ENABLE, 32'hF);
		chk_word({31'h0, irq}, 32'h1);
		ahb(1'b1, QDW_REG_IRQ_CLEAR, 32'hF);
		rd(QDW_REG_IRQ_STATUS, 32'h0);
		chk_word({31'h0, irq}, 32'h0);
		$display("test chain done");

		// page index out of range halts after write back, no transaction
		put_desc(32'h1100, 32'h1, 32'h1, 32'h0010_5C80, 32'h0000_5000);
		exp_q = '{{19'h0, 32'h1100}, {19'h0, 32'h1108}};
		ahb(1'b1, QDW_REG_HEAD, 32'h0000_1100);
		ahb(1'b1, QDW_REG_CTRL, 32'h3);
		wait_done;
		rd(QDW_REG_IRQ_STATUS, 32'h4);
		chk_word({31'h0, irq}, 32'h1);
		$display("test halt done");
		end_of_test;
	end
endmodule
